// *** rtl/pisl_top.sv ***
// Two-wire slave front end of a volatile digital potentiometer and its
// receive FIFO. Assumes an outside master drives the serial clock and that
// the bus wire is resolved from SDA_O and SDA_OE_O outside this file.
// Function
// R1 - Seven-bit addressing only, no ten-bit format.
// R2 - Works up to standard, fast, high-speed rates.
// R3 - Master makes the serial clock always.
// R4 - Start is data falling while clock high.
// R5 - Data changes only while clock is low.
// R6 - Acknowledge by pulling data low, ninth clock.
// R7 - Not-acknowledge leaves the data line released.
// R8 - General call acknowledged only when enabled.
// R9 - Acknowledge own address, refuse other addresses.
// R10 - Refuse unsupported location and command pairs.
// R11 - After error a start resets the machine.
// R12 - Repeated start continues with the same slave.
// R13 - Collision while sending resets the interface.
// R14 - Stop ends transfer and resets interface.
// R15 - Never hold the clock line low.
// R16 - Malformed frames abort before changing state.
// R17 - First byte after start is address.
// R18 - Address is 0101 plus three pins.
// R19 - Absent address pins count as one.
// R20 - Tolerate other masters without state corruption.
// R21 - Sample data on each clock rising edge.
// R22 - Latch lowest address pin after reset.
// R23 - High-speed code refused, high-speed mode entered.
// R24 - Leave high-speed mode at next stop.
// R25 - Synchronise lines, detect conditions from synchronised.
`timescale 1ns/1ps

// ==============================================================
// Receive FIFO with a registered output stage.
// ==============================================================
module pisl_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	// Pointer width; DEPTH must be a power of two so pointers wrap.
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words.
	logic [AW-1:0] wr_q; // Write pointer.
	logic [AW-1:0] rd_q; // Read pointer.
	logic [AW:0] cnt_q; // Words held in storage.
	wire push_w; // A word enters storage.
	wire load_w; // A word moves to the output stage.
	wire drop_w; // The output stage empties.

	assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
	assign push_w = ce_i & in_valid_i & in_ready_o;
	assign load_w = ce_i & (cnt_q != '0) & (~out_valid_o | out_ready_i);
	assign drop_w = ce_i & out_valid_o & out_ready_i & ~load_w;

	// Storage writes need no reset.
	always_ff @(posedge clk_i)
	begin
		if (push_w)
			mem_q[wr_q] <= in_data_i;
	end

	// Pointers, count and output stage.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end
		else if (ce_i)
		begin
			if (push_w)
				wr_q <= wr_q + 1'b1;
			if (load_w)
			begin
				out_data_o <= mem_q[rd_q];
				out_valid_o <= 1'b1;
				rd_q <= rd_q + 1'b1;
			end
			else if (drop_w)
				out_valid_o <= 1'b0;
			cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(load_w);
		end
	end
endmodule // pisl_fifo

// ==============================================================
// Slave front end.
// ==============================================================
module pisl_top #(
	parameter logic [2:0] PIN_PRESENT = 3'h7, // Address pins fitted.
	parameter int FIFO_DEPTH = 8 // Receive FIFO depth.
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic CE_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic HW_ADDR_PIN_0_I,
	input wire logic HW_ADDR_PIN_1_I,
	input wire logic HW_ADDR_PIN_2_I,
	input wire logic GENERAL_CALL_ENABLE_I,
	input wire logic [63:0] CMD_VALID_MAP_I,
	input wire logic [7:0] RD_DATA_I,
	output logic RD_REQ_O,
	output logic RX_VALID_O,
	output logic [7:0] RX_DATA_O,
	output logic RX_IS_CMD_O,
	input wire logic RX_READY_I,
	output logic HS_MODE_O,
	output logic BUSY_O,
	output logic ABORT_O,
	output logic HV_CMD_O,
	output logic ADDR_PIN0_LATCHED_O
);
	// ==========================================================
	// Synchronisers; the clock pin carries no clock here.
	// ==========================================================
	logic scl_s1_q, scl_s2_q, scl_s3_q; // Clock line stages.
	logic sda_s1_q, sda_s2_q, sda_s3_q; // Data line stages.
	logic [2:0] pin_s1_q, pin_s2_q; // Address pin stages.

	// Two flops per line, a third only for edge finding.
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end
		else if (CE_I)
		begin
			scl_s1_q <= SCL_I; // R25
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= SDA_I;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// Address pins have no reset, so the strap sees their level in reset.
	always_ff @(posedge CLK_I)
	begin
		if (CE_I)
		begin
			pin_s1_q <= {HW_ADDR_PIN_2_I, HW_ADDR_PIN_1_I, HW_ADDR_PIN_0_I};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ==========================================================
	// Line events from synchronised values.
	// ==========================================================
	wire scl_high_w = scl_s2_q & scl_s3_q; // Clock held high.
	wire rise_w = CE_I & scl_s2_q & ~scl_s3_q; // R21 R2
	wire fall_w = CE_I & ~scl_s2_q & scl_s3_q; // Clock falling edge.
	wire start_w = CE_I & scl_high_w & sda_s3_q & ~sda_s2_q; // R4 R12
	wire stop_w = CE_I & scl_high_w & ~sda_s3_q & sda_s2_q; // R14

	// ==========================================================
	// Strap capture of the lowest address pin.
	// ==========================================================
	logic pin0_q; // Latched lowest pin level.
	logic latched_q; // Set once the strap is caught.

	// Follows the pin while reset is held, then keeps the last level.
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			pin0_q <= pin_s2_q[0]; // R22
			latched_q <= 1'b0;
		end
		else if (CE_I && !latched_q)
			latched_q <= 1'b1;
	end

	// ==========================================================
	// Frame machine state.
	// ==========================================================
	pisl_pkg::pisl_state_t state_q; // Frame state.
	logic [3:0] bit_q; // Clock rises seen in this byte.
	logic [7:0] shift_q; // Received byte.
	logic [7:0] tx_q; // Byte being sent.
	logic oe_q; // Data line pulled low.
	logic mnack_q; // Master refused the last read byte.
	logic hs_q; // High-speed mode.
	logic rd_req_q; // Read byte taken.
	logic abort_q; // Frame cut short.
	logic busy_q; // Between start and stop.
	logic hv_q; // Live level of the high-voltage input.
	logic sda_o_q; // Level driven when enabled.

	// ==========================================================
	// Address and command decoding.
	// ==========================================================
	wire [2:0] pin_eff_w; // Absent pins read as one.
	assign pin_eff_w = {PIN_PRESENT[2] ? pin_s2_q[2] : 1'b1,
		PIN_PRESENT[1] ? pin_s2_q[1] : 1'b1,
		PIN_PRESENT[0] ? pin0_q : 1'b1}; // R19
	wire [6:0] own_w = {pisl_pkg::ADDR_FIXED, pin_eff_w}; // R18 R1
	wire addr_hit_w = (shift_q[7:1] == own_w); // R9
	wire gc_hit_w = (shift_q == pisl_pkg::GC_ADDR);
	wire hs_hit_w = (shift_q[7:3] == pisl_pkg::HS_CODE); // R23
	wire [5:0] cmd_idx_w = {shift_q[pisl_pkg::LOC_MSB:pisl_pkg::LOC_LSB],
		shift_q[pisl_pkg::OP_MSB:pisl_pkg::OP_LSB]};
	wire cmd_ok_w = CMD_VALID_MAP_I[cmd_idx_w]; // R10
	wire fifo_ready_w; // Receive FIFO has room.
	wire addr_ack_w = addr_hit_w | (gc_hit_w & GENERAL_CALL_ENABLE_I); // R8
	wire is_addr_w = (state_q == pisl_pkg::ST_ADDR);
	wire is_cmd_w = (state_q == pisl_pkg::ST_CMD);
	wire is_wdata_w = (state_q == pisl_pkg::ST_WDATA);
	wire is_rdata_w = (state_q == pisl_pkg::ST_RDATA);
	wire active_w = is_addr_w | is_cmd_w | is_wdata_w | is_rdata_w;
	// The condition's own clock rise counts one bit, so a cut needs two.
	wire cut_w = active_w && (bit_q != pisl_pkg::BIT_ZERO) &&
		(bit_q != pisl_pkg::BIT_ZERO + 4'h1); // R16
	// Acknowledge wanted for the byte just received.
	wire ack_w = is_addr_w ? addr_ack_w :
		is_cmd_w ? (cmd_ok_w & fifo_ready_w) :
		is_wdata_w ? fifo_ready_w : 1'b0; // R6 R7
	wire ack_phase_w = fall_w & (bit_q == pisl_pkg::BIT_ACK);
	// Bytes only reach the FIFO once acknowledged.
	wire push_w = ack_phase_w & (is_cmd_w | is_wdata_w) & ack_w; // R16
	// A released bit read back low means another driver won.
	wire collide_w = rise_w & is_rdata_w & ~oe_q & ~sda_s2_q &
		(bit_q != pisl_pkg::BIT_ACK); // R13 R20
	// Next state after the address byte.
	wire pisl_pkg::pisl_state_t addr_next_w = addr_hit_w ?
		(shift_q[0] ? pisl_pkg::ST_RDATA : pisl_pkg::ST_CMD) :
		addr_ack_w ? pisl_pkg::ST_WDATA : pisl_pkg::ST_WAIT;

	// ==========================================================
	// Frame machine.
	// ==========================================================
	// Start and stop take priority over bit events.
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			state_q <= pisl_pkg::ST_IDLE;
			bit_q <= pisl_pkg::BIT_ZERO;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			oe_q <= 1'b0;
			mnack_q <= 1'b0;
			hs_q <= 1'b0;
			rd_req_q <= 1'b0;
			abort_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (CE_I)
		begin
			rd_req_q <= 1'b0;
			abort_q <= 1'b0;
			if (start_w)
			begin
				state_q <= pisl_pkg::ST_ADDR; // R17 R11 R12
				bit_q <= pisl_pkg::BIT_ZERO;
				oe_q <= 1'b0;
				busy_q <= 1'b1;
				abort_q <= cut_w; // R16
			end
			else if (stop_w)
			begin
				state_q <= pisl_pkg::ST_IDLE; // R14
				bit_q <= pisl_pkg::BIT_ZERO;
				oe_q <= 1'b0;
				hs_q <= 1'b0; // R24
				busy_q <= 1'b0;
				abort_q <= cut_w;
			end
			else if (collide_w)
			begin
				state_q <= pisl_pkg::ST_WAIT; // R13
				bit_q <= pisl_pkg::BIT_ZERO;
				abort_q <= 1'b1;
			end
			else if (rise_w && active_w)
			begin
				if (bit_q == pisl_pkg::BIT_ACK)
				begin
					mnack_q <= sda_s2_q;
					bit_q <= pisl_pkg::BIT_ACK_END;
				end
				else
				begin
					shift_q <= {shift_q[6:0], sda_s2_q}; // R21
					bit_q <= bit_q + 4'h1;
				end
			end
			else if (fall_w && active_w)
			begin
				case (bit_q)
					pisl_pkg::BIT_ACK:
					begin
						oe_q <= ack_w; // R6 R7 R5
						abort_q <= ~ack_w & ~is_rdata_w & ~(is_addr_w & hs_hit_w);
						if (is_addr_w && hs_hit_w && !addr_ack_w)
						begin
							hs_q <= 1'b1; // R23
							state_q <= pisl_pkg::ST_WAIT;
						end
						else if (is_addr_w)
							state_q <= addr_next_w; // R9
						else if (!ack_w && !is_rdata_w)
							state_q <= pisl_pkg::ST_WAIT; // R10
						else if (is_cmd_w)
							state_q <= pisl_pkg::ST_WDATA;
					end
					pisl_pkg::BIT_ACK_END:
					begin
						bit_q <= pisl_pkg::BIT_ZERO;
						if (is_rdata_w && !mnack_q)
						begin
							tx_q <= RD_DATA_I; // R15
							oe_q <= ~RD_DATA_I[7];
							rd_req_q <= 1'b1;
						end
						else
						begin
							oe_q <= 1'b0;
							if (is_rdata_w)
								state_q <= pisl_pkg::ST_WAIT;
						end
					end
					default:
					begin
						// Shift the next read bit out while the clock is low.
						if (is_rdata_w && bit_q != pisl_pkg::BIT_ZERO)
						begin
							tx_q <= {tx_q[6:0], 1'b0}; // R5
							oe_q <= ~tx_q[6];
						end
					end
				endcase
			end
		end
	end

	// Output flops that do not belong to the frame machine.
	always_ff @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			hv_q <= 1'b1;
			sda_o_q <= 1'b0;
		end
		else if (CE_I)
		begin
			hv_q <= pin_s2_q[0];
			sda_o_q <= 1'b0;
		end
	end

	// ==========================================================
	// Receive FIFO.
	// ==========================================================
	wire [8:0] rx_word_w; // FIFO output word.
	pisl_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.ce_i(CE_I),
		.in_valid_i(push_w),
		.in_data_i({is_cmd_w, shift_q}),
		.in_ready_o(fifo_ready_w),
		.out_valid_o(RX_VALID_O),
		.out_data_o(rx_word_w),
		.out_ready_i(RX_READY_I)
	);

	// The serial clock is never driven, so no stretching exists.
	assign SDA_O = sda_o_q; // R15 R3
	assign SDA_OE_O = oe_q;
	assign RD_REQ_O = rd_req_q;
	assign RX_DATA_O = rx_word_w[7:0];
	assign RX_IS_CMD_O = rx_word_w[8];
	assign HS_MODE_O = hs_q;
	assign BUSY_O = busy_q;
	assign ABORT_O = abort_q;
	assign HV_CMD_O = hv_q;
	assign ADDR_PIN0_LATCHED_O = pin0_q;

	// ==========================================================
	// Assertions.
	// ==========================================================
	sequence s_ack_phase;
		ack_phase_w && active_w;
	endsequence

	property p_start_addr;
		@(posedge CLK_I) disable iff (RESET_I)
		start_w |=> is_addr_w && bit_q == pisl_pkg::BIT_ZERO && !oe_q;
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("no address state after start"); // R4

	property p_stop_idle;
		@(posedge CLK_I) disable iff (RESET_I)
		stop_w |=> !BUSY_O && !hs_q && !oe_q;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not reset"); // R14

	property p_own_ack;
		@(posedge CLK_I) disable iff (RESET_I)
		s_ack_phase ##0 (is_addr_w && addr_hit_w) |=> oe_q;
	endproperty
	a_own_ack: assert property (p_own_ack) else $error("own address not acknowledged"); // R9

	property p_foreign_nack;
		@(posedge CLK_I) disable iff (RESET_I)
		s_ack_phase ##0 (is_addr_w && !addr_hit_w && !gc_hit_w) |=>
			!oe_q && state_q == pisl_pkg::ST_WAIT;
	endproperty
	a_foreign_nack: assert property (p_foreign_nack) else $error("foreign address acknowledged"); // R7

	property p_gc;
		@(posedge CLK_I) disable iff (RESET_I)
		s_ack_phase ##0 (is_addr_w && gc_hit_w) |=>
			oe_q == $past(GENERAL_CALL_ENABLE_I);
	endproperty
	a_gc: assert property (p_gc) else $error("general call answer wrong"); // R8

	property p_hs;
		@(posedge CLK_I) disable iff (RESET_I)
		s_ack_phase ##0 (is_addr_w && hs_hit_w) |=> hs_q && !oe_q;
	endproperty
	a_hs: assert property (p_hs) else $error("high-speed code mishandled"); // R23

	property p_bad_cmd;
		@(posedge CLK_I) disable iff (RESET_I)
		s_ack_phase ##0 (is_cmd_w && !cmd_ok_w) |=>
			!oe_q && state_q == pisl_pkg::ST_WAIT ##1 !oe_q;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("bad command acknowledged"); // R10

	property p_oe_low_clock;
		@(posedge CLK_I) disable iff (RESET_I)
		$changed(oe_q) |-> !$past(scl_s2_q);
	endproperty
	a_oe_low_clock: assert property (p_oe_low_clock) else $error("data moved while clock high"); // R5

	property p_push_acked;
		@(posedge CLK_I) disable iff (RESET_I)
		push_w |=> oe_q;
	endproperty
	a_push_acked: assert property (p_push_acked) else $error("unacknowledged byte stored"); // R16

	property p_strap_hold;
		@(posedge CLK_I) disable iff (RESET_I)
		latched_q && $past(latched_q) |-> $stable(pin0_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap level moved"); // R22

	property p_collide;
		@(posedge CLK_I) disable iff (RESET_I)
		collide_w && !start_w && !stop_w |=> state_q == pisl_pkg::ST_WAIT && ABORT_O;
	endproperty
	a_collide: assert property (p_collide) else $error("collision not handled"); // R13
endmodule // pisl_top

// *** inc/pisl_pkg.sv ***
// Constants, field layouts and state codes of the two-wire slave front end.
// Assumes an oversampling system clock well above the bus bit rate.

package pisl_pkg;

	// ==========================================================
	// Clock and bus rates.
	// ==========================================================
	// System clock rate in hertz.
	localparam int CLK_HZ = 40_000_000;
	// Standard mode serial clock ceiling in hertz.
	localparam int SCL_STD_HZ = 100_000;
	// Fast mode serial clock ceiling in hertz.
	localparam int SCL_FAST_HZ = 400_000;
	// High-speed mode serial clock ceiling in hertz.
	localparam int SCL_HS_HZ = 3_400_000;
	// Whole system clocks per bit at the fastest serial clock.
	localparam int HS_BIT_CYC = CLK_HZ / SCL_HS_HZ;

	// ==========================================================
	// Address byte decoding.
	// ==========================================================
	// Fixed upper nibble of the own slave address.
	localparam logic [3:0] ADDR_FIXED = 4'h5;
	// General call address byte.
	localparam logic [7:0] GC_ADDR = 8'h00;
	// Upper five bits of the high-speed master code.
	localparam logic [4:0] HS_CODE = 5'h01;

	// ==========================================================
	// Command byte fields.
	// ==========================================================
	// Memory location field position.
	localparam int LOC_MSB = 7;
	localparam int LOC_LSB = 4;
	// Command operation field position.
	localparam int OP_MSB = 3;
	localparam int OP_LSB = 2;

	// ==========================================================
	// Bit counter marks.
	// ==========================================================
	// Count after the eighth data rise: acknowledge phase.
	localparam logic [3:0] BIT_ACK = 4'h8;
	// Count after the ninth rise: end of acknowledge bit.
	localparam logic [3:0] BIT_ACK_END = 4'h9;
	// Count value of a fresh byte.
	localparam logic [3:0] BIT_ZERO = 4'h0;

	// ==========================================================
	// Frame states.
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_CMD = 3'h2,
		ST_WDATA = 3'h3,
		ST_RDATA = 3'h4,
		ST_WAIT = 3'h5
	} pisl_state_t;

endpackage

// *** verification/pisl_master_model.sv ***
// Behavioural two-wire bus master facing the slave front end.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps

// ==========================================================
// Bus master model.
// ==========================================================
module pisl_master_model (
	output logic scl_o,
	output logic pull_o,
	input wire logic sda_i
);
	// Nine wire levels seen during the last byte, MSB first.
	logic [8:0] rx;
	// Fires when a byte and its acknowledge bit are complete.
	event done_ev;

	// Both lines idle released; the clock stands still between frames.
	initial
	begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	// One bit of 200 ns: data set in the low phase, read late in high.
	task automatic clk_bit(input logic b, output logic s);
		pull_o = ~b;
		#80;
		scl_o = 1'b1;
		#70;
		s = sda_i;
		#10;
		scl_o = 1'b0;
		#40;
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		pull_o = 1'b0;
		#40;
		scl_o = 1'b1;
		#80;
		pull_o = 1'b1;
		#80;
		scl_o = 1'b0;
		#40;
	endtask

	// Stop: data rises while the clock is high, then the bus rests.
	task automatic stop();
		pull_o = 1'b1;
		#80;
		scl_o = 1'b1;
		#80;
		pull_o = 1'b0;
		#200;
	endtask

	// Eight bits and the acknowledge bit; a 0 in tx pulls the wire.
	task automatic xfer(input logic [8:0] tx);
		for (int i = 8; i >= 0; i--)
		begin
			clk_bit(tx[i], rx[i]);
		end
		->done_ev;
	endtask
endmodule // pisl_master_model

// *** verification/test_pot_i2c_slave_interface.sv ***
// Self-checking bench of the slave front end with its receive FIFO.
// Assumes the bus master model and the design package are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin total_checks++; if ((e) !== (s)) begin \
	failures++; $display("Error %s expected %h seen %h", nm, e, s); end end

// ==========================================================
// Bench top.
// ==========================================================
module test_pot_i2c_slave_interface;
	logic CLK_I, RESET_I, CE_I, SDA_O, SDA_OE_O, HW_ADDR_PIN_0_I;
	logic HW_ADDR_PIN_1_I, HW_ADDR_PIN_2_I, GENERAL_CALL_ENABLE_I;
	logic [63:0] CMD_VALID_MAP_I;
	logic [7:0] RD_DATA_I, RX_DATA_O, own, cmd, d, rd1, rd2;
	logic RD_REQ_O, RX_VALID_O, RX_IS_CMD_O, RX_READY_I, HS_MODE_O;
	logic BUSY_O, ABORT_O, HV_CMD_O, ADDR_PIN0_LATCHED_O, p1, p0, dummy;
	logic [8:0] bq[$];
	logic [8:0] rq[$];
	logic [8:0] exp_rx, exp_bus;
	logic [7:0] bad[4];
	wire scl;
	wire m_pull;
	// Open-drain data wire with pull-up, pulled by either party.
	wire sda = (SDA_OE_O ? SDA_O : 1'b1) & ~m_pull;
	int failures, total_checks, cycles, abort_cnt, rdreq_cnt, a0;

	pisl_top #(.PIN_PRESENT(3'h3), .FIFO_DEPTH(8)) pisl_top_inst (
		.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
		.HW_ADDR_PIN_0_I(HW_ADDR_PIN_0_I), .HW_ADDR_PIN_1_I(HW_ADDR_PIN_1_I),
		.HW_ADDR_PIN_2_I(HW_ADDR_PIN_2_I),
		.GENERAL_CALL_ENABLE_I(GENERAL_CALL_ENABLE_I),
		.CMD_VALID_MAP_I(CMD_VALID_MAP_I), .RD_DATA_I(RD_DATA_I),
		.RD_REQ_O(RD_REQ_O), .RX_VALID_O(RX_VALID_O), .RX_DATA_O(RX_DATA_O),
		.RX_IS_CMD_O(RX_IS_CMD_O), .RX_READY_I(RX_READY_I),
		.HS_MODE_O(HS_MODE_O), .BUSY_O(BUSY_O), .ABORT_O(ABORT_O),
		.HV_CMD_O(HV_CMD_O), .ADDR_PIN0_LATCHED_O(ADDR_PIN0_LATCHED_O));

	pisl_master_model pisl_master_model_inst (
		.scl_o(scl), .pull_o(m_pull), .sda_i(sda));

	// System clock of 25 ns.
	initial
	begin
		CLK_I = 1'b0;
		forever #12.5 CLK_I = ~CLK_I;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Notes the nine expected wire levels, then runs the byte.
	task automatic bus(input logic [8:0] tx, input logic [8:0] ex);
		bq.push_back(ex);
		pisl_master_model_inst.xfer(tx);
	endtask

	// Master writes b; ack high means the slave must pull the ninth bit.
	task automatic wr(input logic [7:0] b, input logic ack);
		bus({b, 1'b1}, {b, ~ack});
	endtask

	// Master reads and expects b, then answers with mack.
	task automatic rd(input logic [7:0] b, input logic mack);
		bus({8'hFF, mack}, {b, mack});
	endtask

	// Compares each finished byte with the oldest note.
	always @(pisl_master_model_inst.done_ev)
	begin
		exp_bus = bq.pop_front();
		`CHK("bus byte", exp_bus, pisl_master_model_inst.rx)
	end

	// Counts pulses, takes FIFO words, and cuts a hang short.
	always @(posedge CLK_I)
	begin
		cycles++;
		if (ABORT_O === 1'b1)
			abort_cnt++;
		if (RD_REQ_O === 1'b1)
			rdreq_cnt++;
		if (RX_VALID_O === 1'b1 && RX_READY_I === 1'b1)
		begin
			exp_rx = (rq.size() != 0) ? rq.pop_front() : 'x;
			`CHK("rx word", exp_rx, {RX_IS_CMD_O, RX_DATA_O})
		end
		if (cycles > 30000)
		begin
			failures++;
			close_out();
		end
	end

	// ==========================================================
	// Main sequence.
	// ==========================================================
	initial
	begin
		void'($urandom(32'h45cf_7b62));
		{p1, p0} = 2'($urandom);
		RESET_I = 1'b1;
		CE_I = 1'b1;
		HW_ADDR_PIN_0_I = p0;
		HW_ADDR_PIN_1_I = p1;
		HW_ADDR_PIN_2_I = 1'b0;
		GENERAL_CALL_ENABLE_I = 1'b0;
		CMD_VALID_MAP_I = {$urandom, $urandom};
		RD_DATA_I = 8'h00;
		RX_READY_I = 1'b1;
		own = {pisl_pkg::ADDR_FIXED, 1'b1, p1, p0, 1'b0};
		repeat (10) @(posedge CLK_I);
		RESET_I <= 1'b0;
		repeat (6) @(posedge CLK_I);
		HW_ADDR_PIN_0_I <= ~p0;
		repeat (6) @(posedge CLK_I);
		`CHK("hv level", ~p0, HV_CMD_O)
		`CHK("pin0 strap", p0, ADDR_PIN0_LATCHED_O)
		// Commands alternately refused and accepted through the map.
		for (int k = 0; k < 6; k++)
		begin
			cmd = 8'($urandom);
			CMD_VALID_MAP_I[{cmd[7:4], cmd[3:2]}] <= k[0];
			d = 8'($urandom);
			a0 = abort_cnt;
			@(posedge CLK_I);
			pisl_master_model_inst.start();
			wr(own, 1'b1);
			`CHK("busy", 1'b1, BUSY_O)
			if (k[0])
				rq.push_back({1'b1, cmd});
			wr(cmd, k[0]);
			if (k[0])
			begin
				rq.push_back({1'b0, d});
				wr(d, 1'b1);
			end
			pisl_master_model_inst.stop();
			`CHK("idle", 1'b0, BUSY_O)
			`CHK("abort count", a0 + 1 - k[0], abort_cnt)
		end
		// Foreign addresses, absent pin read as one, disabled call.
		bad = '{own ^ 8'h08, own ^ 8'h02, own ^ 8'h80, 8'h00};
		foreach (bad[i])
		begin
			pisl_master_model_inst.start();
			wr(bad[i], 1'b0);
			pisl_master_model_inst.stop();
		end
		GENERAL_CALL_ENABLE_I <= 1'b1;
		d = 8'($urandom);
		pisl_master_model_inst.start();
		wr(8'h00, 1'b1);
		rq.push_back({1'b0, d});
		wr(d, 1'b1);
		pisl_master_model_inst.stop();
		GENERAL_CALL_ENABLE_I <= 1'b0;
		// High-speed code, then a repeated start to our address.
		pisl_master_model_inst.start();
		wr({pisl_pkg::HS_CODE, 3'($urandom)}, 1'b0);
		`CHK("hs mode", 1'b1, HS_MODE_O)
		pisl_master_model_inst.start();
		wr(own, 1'b1);
		pisl_master_model_inst.stop();
		`CHK("hs left", 1'b0, HS_MODE_O)
		// Start inside a byte drops the half byte.
		a0 = abort_cnt;
		pisl_master_model_inst.start();
		wr(own, 1'b1);
		repeat (4) pisl_master_model_inst.clk_bit(1'b1, dummy);
		pisl_master_model_inst.start();
		`CHK("abort", 1'b1, abort_cnt != a0)
		wr(own, 1'b1);
		pisl_master_model_inst.stop();
		// Two read bytes, master acknowledges the first only.
		{rd1, rd2} = 16'($urandom);
		RD_DATA_I <= rd1;
		pisl_master_model_inst.start();
		wr(own | 8'h01, 1'b1);
		repeat (6) @(posedge CLK_I);
		RD_DATA_I <= rd2;
		rd(rd1, 1'b0);
		rd(rd2, 1'b1);
		pisl_master_model_inst.stop();
		// Master pulls low while the slave sends a one.
		RD_DATA_I <= 8'hFF;
		a0 = abort_cnt;
		pisl_master_model_inst.start();
		wr(own | 8'h01, 1'b1);
		bus({8'h7F, 1'b1}, 9'h0FF);
		`CHK("collision", 1'b1, abort_cnt != a0)
		pisl_master_model_inst.stop();
		`CHK("load pulses", 3, rdreq_cnt)
		// Consumer stalls: nine words fit, the tenth is refused.
		RX_READY_I <= 1'b0;
		CMD_VALID_MAP_I[0] <= 1'b1;
		pisl_master_model_inst.start();
		wr(own, 1'b1);
		rq.push_back(9'h100);
		wr(8'h00, 1'b1);
		for (int j = 0; j < 8; j++)
		begin
			d = 8'($urandom);
			rq.push_back({1'b0, d});
			wr(d, 1'b1);
		end
		wr(8'hA5, 1'b0);
		pisl_master_model_inst.stop();
		RX_READY_I <= 1'b1;
		for (int w = 0; w < 100 && rq.size() != 0; w++)
			@(posedge CLK_I);
		repeat (4) @(posedge CLK_I);
		`CHK("drained", 0, rq.size())
		`CHK("rx empty", 1'b0, RX_VALID_O)
		close_out();
	end
endmodule // test_pot_i2c_slave_interface
